// ==== hdl/acsa_defines.svh ====
// What this block does
// - restart bit: resume after power loss, else cold
// - hold bit clear: clear memory on mode group switch
// - hold bit retained: keep memory across power loss
// - forced-state hold keeps forced bits across switches
// - switching to run clears forced bits unless a power restore keeping them lands in the same cycle
// - log-clear bit clears log, pointer and itself in the same cycle
// - inhibit bit kills outputs, set on resume
// - unit restart bits self-clear on restart done
// - error-check bits copy master code, self-clear
// - interruption duration in four-digit BCD milliseconds
// - stop-monitor busy and completed flags
// - trace busy, trigger and region-done flags
// - sampling bit starts trace; trigger sets start
// - power-on time stored as BCD bytes
// - interruption time stored as BCD bytes
// - BCD interruption count, cleared by writing zero
// - service-disable bits clear at power-on and stop
// - unit and refresh disable bits suspend servicing
// - host-link and peripheral disable bits suspend servicing
// - message instruction sets flag of its number
// - twenty five-word records, binary last-record pointer
// - append after pointer, shift when full
// - record: code, contents, time and date bytes
`ifndef ACSA_DEFINES_SVH
`define ACSA_DEFINES_SVH
`define ACSA_IX_CTL     10'h000
`define ACSA_IX_URST    10'h001
`define ACSA_IX_ECHK    10'h005
`define ACSA_IX_PDUR    10'h007
`define ACSA_IX_MON     10'h008
`define ACSA_IX_ST0     10'h00a
`define ACSA_IX_ST1     10'h00b
`define ACSA_IX_PT0     10'h00c
`define ACSA_IX_PT1     10'h00d
`define ACSA_IX_PCNT    10'h00e
`define ACSA_IX_SDIS    10'h00f
`define ACSA_IX_LDIS    10'h011
`define ACSA_IX_MSG     10'h063
`define ACSA_IX_LOG_LO  10'h064
`define ACSA_IX_LOG_HI  10'h0c7
`define ACSA_IX_PTR     10'h12c
`define ACSA_IX_RM_LO   10'h1d6
`define ACSA_IX_RM_HI   10'h1dd
`define ACSA_CTL_WMASK  16'hf800
`define ACSA_ECHK_WMASK 16'h00ff
`define ACSA_MON_WMASK  16'h8000
`define ACSA_LDIS_WMASK 16'h0038
`define ACSA_B_RESTART  11
`define ACSA_B_HOLD     12
`define ACSA_B_FHOLD    13
`define ACSA_B_LOGCLR   14
`define ACSA_B_INH      15
`define ACSA_B_STOP     7
`define ACSA_B_STOPDONE 10
`define ACSA_B_TRIG     11
`define ACSA_B_TDONE    12
`define ACSA_B_BUSY     13
`define ACSA_B_TSTART   14
`define ACSA_B_SAMPLE   15
`define ACSA_B_HOST     3
`define ACSA_B_PERIPH   4
`define ACSA_B_REFRESH  5
`define ACSA_LOG_RECS   16'h0014
`define ACSA_REC_WORDS  5
`define ACSA_BCD_MAX    16'h9999
`define ACSA_CLK_NS     10
`define ACSA_MS_NS      1000000
`endif

// ==== hdl/acsa_pkg.sv ====
package acsa_pkg;
  typedef enum logic [1:0] {ACSA_PROG, ACSA_DEBUG, ACSA_MON, ACSA_RUN} acsa_mode_t;
  typedef struct packed {
    logic [15:0]        ctl;
    logic [15:0]        urst;
    logic [15:0]        echk;
    logic [15:0]        pdur;
    logic [15:0]        mon;
    logic [15:0]        st0;
    logic [15:0]        st1;
    logic [15:0]        pt0;
    logic [15:0]        pt1;
    logic [15:0]        pcnt;
    logic [15:0]        sdis;
    logic [15:0]        ldis;
    logic [15:0]        msg;
    logic [15:0]        ptr;
    logic [7:0][15:0]   rmcode;
    logic [99:0][15:0]  log;
    acsa_mode_t         mode;
    logic               ack;
    logic [15:0]        rdata;
    logic               down;
    logic               first;
    logic [16:0]        msdiv;
    logic               resume;
    logic               cold;
    logic               clr_io;
    logic               clr_force;
  } acsa_state_t;
endpackage

// ==== hdl/acsa_top.sv ====
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "acsa_defines.svh"
module acsa_top import acsa_pkg::*; #(
  parameter int MS_CYC = `ACSA_MS_NS / `ACSA_CLK_NS
) (
  input  wire logic         SYS_CLK_I,
  input  wire logic         RST_B_I,
  input  wire logic [11:0]  AVS_ADDRESS_I,
  input  wire logic         AVS_READ_I,
  input  wire logic         AVS_WRITE_I,
  input  wire logic [31:0]  AVS_WRITEDATA_I,
  input  wire logic [3:0]   AVS_BYTEENABLE_I,
  output logic [31:0]       AVS_READDATA_O,
  output logic              AVS_WAITREQUEST_O,
  input  wire acsa_mode_t   MODE_I,
  input  wire logic         HOLD_CFG_I,
  input  wire logic         FHOLD_CFG_I,
  input  wire logic         PWR_FAIL_I,
  input  wire logic         PWR_RESTORE_I,
  input  wire logic [47:0]  CAL_I,
  input  wire logic [15:0]  UNIT_RST_DONE_I,
  input  wire logic [127:0] RM_CODE_I,
  input  wire logic         STOPMON_START_I,
  input  wire logic         STOPMON_DONE_I,
  input  wire logic         TRACE_START_I,
  input  wire logic         TRACE_TRIG_I,
  input  wire logic         TRACE_REGION_I,
  input  wire logic         TRACE_END_I,
  input  wire logic         PLC_STOP_I,
  input  wire logic         MSG_EXEC_I,
  input  wire logic [2:0]   MSG_NUM_I,
  input  wire logic         ERR_LOG_I,
  input  wire logic [15:0]  ERR_CODE_I,
  input  wire logic [15:0]  ERR_INFO_I,
  output logic              RESUME_O,
  output logic              COLD_START_O,
  output logic              CLR_IO_MEM_O,
  output logic              CLR_FORCE_O,
  output logic              IOM_KEEP_O,
  output logic              FORCE_KEEP_O,
  output logic              OUTPUT_INHIBIT_INDICATOR_O,
  output logic [15:0]       UNIT_RST_O,
  output logic              TRACE_SAMPLE_O,
  output logic [15:0]       UNIT_SVC_DIS_O,
  output logic              HOST_SVC_DIS_O,
  output logic              PERIPH_SVC_DIS_O,
  output logic              REFRESH_DIS_O
);

  localparam logic [16:0] MS_LAST = 17'(MS_CYC - 1);

  acsa_state_t s_q;
  acsa_state_t s_d;
  logic        req;
  logic        wr;
  logic [9:0]  idx;
  logic [15:0] bem;
  logic [15:0] wd;
  logic [15:0] rd;
  logic [9:0]  lix;
  logic [9:0]  rix;
  logic [15:0] pos;
  logic        grp_chg;
  logic        mode_chg;

  // saturates at 9999 so the count never wraps to zero
  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    if (v == `ACSA_BCD_MAX) return v;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (r[i*4+:4] == 4'h9) begin
          r[i*4+:4] = 4'h0;
        end else begin
          r[i*4+:4] = r[i*4+:4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] m);
    return (o & ~m) | (wd & m);
  endfunction

  assign req      = AVS_READ_I | AVS_WRITE_I;
  assign wr       = AVS_WRITE_I & s_q.ack;
  assign idx      = AVS_ADDRESS_I[11:2];
  assign bem      = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  assign wd       = AVS_WRITEDATA_I[15:0];
  assign lix      = idx - `ACSA_IX_LOG_LO;
  assign rix      = idx - `ACSA_IX_RM_LO;
  assign mode_chg = MODE_I != s_q.mode;
  assign grp_chg  = MODE_I[1] != s_q.mode[1];

  always_comb begin
    rd = 16'h0000;
    case (idx)
      `ACSA_IX_CTL:  rd = s_q.ctl;
      `ACSA_IX_URST: rd = s_q.urst;
      `ACSA_IX_ECHK: rd = s_q.echk;
      `ACSA_IX_PDUR: rd = s_q.pdur;
      `ACSA_IX_MON:  rd = s_q.mon;
      `ACSA_IX_ST0:  rd = s_q.st0;
      `ACSA_IX_ST1:  rd = s_q.st1;
      `ACSA_IX_PT0:  rd = s_q.pt0;
      `ACSA_IX_PT1:  rd = s_q.pt1;
      `ACSA_IX_PCNT: rd = s_q.pcnt;
      `ACSA_IX_SDIS: rd = s_q.sdis;
      `ACSA_IX_LDIS: rd = s_q.ldis;
      `ACSA_IX_MSG:  rd = s_q.msg;
      `ACSA_IX_PTR:  rd = s_q.ptr;
      default: begin
        if (idx >= `ACSA_IX_LOG_LO && idx <= `ACSA_IX_LOG_HI) begin
          rd = s_q.log[lix[6:0]];
        end else if (idx >= `ACSA_IX_RM_LO && idx <= `ACSA_IX_RM_HI) begin
          rd = s_q.rmcode[rix[2:0]];
        end
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    pos = 16'h0000;
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack) begin
      s_d.rdata = rd;
    end
    s_d.resume = 1'b0;
    s_d.cold = 1'b0;
    s_d.clr_io = 1'b0;
    s_d.clr_force = 1'b0;
    s_d.mode = MODE_I;

    // hardware clears come first so a software set in the same cycle wins
    if (s_q.ctl[`ACSA_B_LOGCLR]) begin
      s_d.log = '0;
      s_d.ptr = 16'h0000;
      s_d.ctl[`ACSA_B_LOGCLR] = 1'b0;
    end
    s_d.urst = s_q.urst & ~UNIT_RST_DONE_I;
    for (int m = 0; m < 8; m++) begin
      if (s_q.echk[m]) begin
        s_d.rmcode[m] = RM_CODE_I[m*16+:16];
        s_d.echk[m] = 1'b0;
      end
    end
    if (PLC_STOP_I) begin
      s_d.sdis = 16'h0000;
      s_d.ldis = 16'h0000;
    end

    if (wr) begin
      case (idx)
        `ACSA_IX_CTL:  s_d.ctl = merge(s_d.ctl, bem & `ACSA_CTL_WMASK);
        `ACSA_IX_URST: s_d.urst = merge(s_d.urst, bem);
        `ACSA_IX_ECHK: s_d.echk = merge(s_d.echk, bem & `ACSA_ECHK_WMASK);
        `ACSA_IX_MON:  s_d.mon = merge(s_d.mon, bem & `ACSA_MON_WMASK);
        `ACSA_IX_PCNT: begin
          if (wd == 16'h0000 && bem == 16'hffff) begin
            s_d.pcnt = 16'h0000;
          end
        end
        `ACSA_IX_SDIS: s_d.sdis = merge(s_d.sdis, bem);
        `ACSA_IX_LDIS: s_d.ldis = merge(s_d.ldis, bem & `ACSA_LDIS_WMASK);
        default: s_d.ctl = s_d.ctl;
      endcase
    end

    if (mode_chg) begin
      s_d.clr_io = grp_chg & ~s_q.ctl[`ACSA_B_HOLD];
      s_d.clr_force = ~s_q.ctl[`ACSA_B_FHOLD] | (MODE_I == ACSA_RUN);
    end

    if (s_q.first) begin
      s_d.first = 1'b0;
      s_d.st0 = CAL_I[15:0];
      s_d.st1 = CAL_I[31:16];
    end
    if (PWR_FAIL_I && !s_q.down) begin
      s_d.down = 1'b1;
      s_d.pt0 = CAL_I[15:0];
      s_d.pt1 = CAL_I[31:16];
      s_d.pcnt = bcd_inc(s_d.pcnt);
      s_d.pdur = 16'h0000;
      s_d.msdiv = 17'h00000;
    end else if (s_q.down) begin
      if (s_q.msdiv == MS_LAST) begin
        s_d.msdiv = 17'h00000;
        s_d.pdur = bcd_inc(s_q.pdur);
      end else begin
        s_d.msdiv = s_q.msdiv + 17'h00001;
      end
      if (PWR_RESTORE_I) begin
        s_d.down = 1'b0;
        s_d.st0 = CAL_I[15:0];
        s_d.st1 = CAL_I[31:16];
        s_d.clr_io = ~(s_q.ctl[`ACSA_B_HOLD] & HOLD_CFG_I);
        s_d.clr_force = ~(s_q.ctl[`ACSA_B_FHOLD] & FHOLD_CFG_I);
        if (s_q.ctl[`ACSA_B_RESTART]) begin
          s_d.resume = 1'b1;
          s_d.ctl[`ACSA_B_INH] = 1'b1;
        end else begin
          s_d.cold = 1'b1;
        end
      end
    end

    if (STOPMON_START_I) begin
      s_d.mon[`ACSA_B_STOP] = 1'b1;
      s_d.mon[`ACSA_B_STOPDONE] = 1'b0;
    end else if (STOPMON_DONE_I) begin
      s_d.mon[`ACSA_B_STOP] = 1'b0;
      s_d.mon[`ACSA_B_STOPDONE] = 1'b1;
    end
    if (TRACE_START_I || (s_d.mon[`ACSA_B_SAMPLE] && !s_q.mon[`ACSA_B_SAMPLE])) begin
      s_d.mon[`ACSA_B_BUSY] = 1'b1;
      s_d.mon[`ACSA_B_TRIG] = 1'b0;
      s_d.mon[`ACSA_B_TDONE] = 1'b0;
      s_d.mon[`ACSA_B_TSTART] = 1'b0;
    end else if (TRACE_END_I) begin
      s_d.mon[`ACSA_B_BUSY] = 1'b0;
    end
    if (TRACE_TRIG_I && s_q.mon[`ACSA_B_BUSY]) begin
      s_d.mon[`ACSA_B_TRIG] = 1'b1;
      s_d.mon[`ACSA_B_TSTART] = 1'b1;
    end
    if (TRACE_REGION_I && s_q.mon[`ACSA_B_BUSY]) begin
      s_d.mon[`ACSA_B_TDONE] = 1'b1;
    end

    if (MSG_EXEC_I) begin
      s_d.msg[MSG_NUM_I] = 1'b1;
    end

    // a record arriving with a log clear lands in record 1
    if (ERR_LOG_I) begin
      if (s_d.ptr == `ACSA_LOG_RECS) begin
        for (int w = 0; w < 95; w++) begin
          s_d.log[w] = s_d.log[w+`ACSA_REC_WORDS];
        end
        pos = `ACSA_LOG_RECS - 16'h0001;
      end else begin
        pos = s_d.ptr;
        s_d.ptr = s_d.ptr + 16'h0001;
      end
      s_d.log[pos*`ACSA_REC_WORDS+0] = ERR_CODE_I;
      s_d.log[pos*`ACSA_REC_WORDS+1] = ERR_INFO_I;
      s_d.log[pos*`ACSA_REC_WORDS+2] = CAL_I[15:0];
      s_d.log[pos*`ACSA_REC_WORDS+3] = CAL_I[31:16];
      s_d.log[pos*`ACSA_REC_WORDS+4] = CAL_I[47:32];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      s_q <= '0;
      s_q.first <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign AVS_READDATA_O    = {16'h0000, s_q.rdata};
  assign AVS_WAITREQUEST_O = req & ~s_q.ack;
  assign RESUME_O          = s_q.resume;
  assign COLD_START_O      = s_q.cold;
  assign CLR_IO_MEM_O      = s_q.clr_io;
  assign CLR_FORCE_O       = s_q.clr_force;
  assign IOM_KEEP_O        = s_q.ctl[`ACSA_B_HOLD] & HOLD_CFG_I;
  assign FORCE_KEEP_O      = s_q.ctl[`ACSA_B_FHOLD] & FHOLD_CFG_I;
  assign OUTPUT_INHIBIT_INDICATOR_O         = s_q.ctl[`ACSA_B_INH];
  assign UNIT_RST_O        = s_q.urst;
  assign TRACE_SAMPLE_O    = s_q.mon[`ACSA_B_SAMPLE];
  assign UNIT_SVC_DIS_O    = s_q.sdis;
  assign HOST_SVC_DIS_O    = s_q.ldis[`ACSA_B_HOST];
  assign PERIPH_SVC_DIS_O  = s_q.ldis[`ACSA_B_PERIPH];
  assign REFRESH_DIS_O     = s_q.ldis[`ACSA_B_REFRESH];

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_resume_req;
    s_q.down && !PWR_FAIL_I && PWR_RESTORE_I && s_q.ctl[`ACSA_B_RESTART];
  endsequence
  sequence s_resume_ans;
    RESUME_O && OUTPUT_INHIBIT_INDICATOR_O && !COLD_START_O;
  endsequence

  chk_resume_inhibit: assert property (s_resume_req |=> s_resume_ans)
    else $error("resume did not raise inhibit");
  chk_cold_start: assert property (s_q.down && !PWR_FAIL_I && PWR_RESTORE_I
    && !s_q.ctl[`ACSA_B_RESTART] |=> COLD_START_O && !RESUME_O)
    else $error("cold start missing");
  chk_log_clear: assert property (s_q.ctl[`ACSA_B_LOGCLR] && !ERR_LOG_I && !wr
    |=> s_q.ptr == 16'h0000 && !s_q.ctl[`ACSA_B_LOGCLR])
    else $error("log clear incomplete");
  chk_log_hold_ptr: assert property (ERR_LOG_I && s_q.ptr == `ACSA_LOG_RECS
    && !s_q.ctl[`ACSA_B_LOGCLR] |=> s_q.ptr == `ACSA_LOG_RECS)
    else $error("full pointer moved");
  chk_log_append: assert property (ERR_LOG_I && s_q.ptr < `ACSA_LOG_RECS
    && !s_q.ctl[`ACSA_B_LOGCLR] |=> s_q.ptr == $past(s_q.ptr) + 16'h0001
    && s_q.log[$past(s_q.ptr)*5] == $past(ERR_CODE_I))
    else $error("record not appended");
  chk_mem_clear: assert property (mode_chg && grp_chg && !s_q.ctl[`ACSA_B_HOLD]
    |=> CLR_IO_MEM_O)
    else $error("memory not cleared");
  chk_force_run: assert property (MODE_I == ACSA_RUN && s_q.mode != ACSA_RUN
    |=> CLR_FORCE_O)
    else $error("forced bits kept into run");
  chk_svc_stop: assert property (PLC_STOP_I && !wr
    |=> UNIT_SVC_DIS_O == 16'h0000 && !HOST_SVC_DIS_O && !REFRESH_DIS_O)
    else $error("disable bits survive stop");
  chk_unit_done: assert property (UNIT_RST_DONE_I[0] && !wr |=> !UNIT_RST_O[0])
    else $error("restart bit not cleared");
  chk_msg_flag: assert property (MSG_EXEC_I |=> s_q.msg[$past(MSG_NUM_I)])
    else $error("message flag not set");
  chk_dur_range: assert property (s_q.pdur <= `ACSA_BCD_MAX
    && s_q.pdur[3:0] <= 4'h9)
    else $error("duration not BCD");
  chk_bus_answer: assert property (AVS_READ_I && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O && AVS_READDATA_O[31:16] == 16'h0000)
    else $error("bus answer late");

endmodule

// ==== tb/acsa_tb.sv ====
`timescale 1ns/100ps
`include "acsa_defines.svh"
module testbench import acsa_pkg::*; ;
  logic         SYS_CLK_I        = 1'b0;
  logic         RST_B_I          = 1'b0;
  logic [11:0]  AVS_ADDRESS_I    = 12'h000;
  logic         AVS_READ_I       = 1'b0;
  logic         AVS_WRITE_I      = 1'b0;
  logic [31:0]  AVS_WRITEDATA_I  = 32'h0000_0000;
  logic [3:0]   AVS_BYTEENABLE_I = 4'h3;
  acsa_mode_t   MODE_I           = ACSA_PROG;
  logic         HOLD_CFG_I       = 1'b1;
  logic         FHOLD_CFG_I      = 1'b1;
  logic [47:0]  CAL_I            = 48'h9807_1523_4530;
  logic [127:0] RM_CODE_I        = 128'h0;
  logic [2:0]   MSG_NUM_I        = 3'h0;
  logic [15:0]  ERR_CODE_I       = 16'h0000;
  logic [15:0]  ERR_INFO_I       = 16'h0000;
  // one bit per event input, unit restart-done pulses in the top sixteen
  logic [26:0]  ev               = 27'h0;
  logic [31:0]  AVS_READDATA_O;
  logic         AVS_WAITREQUEST_O;
  logic         RESUME_O, COLD_START_O, CLR_IO_MEM_O, CLR_FORCE_O;
  logic         IOM_KEEP_O, FORCE_KEEP_O, OUTPUT_INHIBIT_INDICATOR_O, TRACE_SAMPLE_O;
  logic         HOST_SVC_DIS_O, PERIPH_SVC_DIS_O, REFRESH_DIS_O;
  logic [15:0]  UNIT_RST_O, UNIT_SVC_DIS_O;
  logic [15:0]  rv;
  int           n_mismatch       = 0;
  int           total_checks     = 0;

  acsa_top #(.MS_CYC(10)) i_dut (
    .SYS_CLK_I, .RST_B_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
    .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O,
    .MODE_I, .HOLD_CFG_I, .FHOLD_CFG_I, .CAL_I, .RM_CODE_I, .MSG_NUM_I,
    .ERR_CODE_I, .ERR_INFO_I,
    .PWR_FAIL_I(ev[0]), .PWR_RESTORE_I(ev[1]), .STOPMON_START_I(ev[2]),
    .STOPMON_DONE_I(ev[3]), .TRACE_START_I(ev[4]), .TRACE_TRIG_I(ev[5]),
    .TRACE_REGION_I(ev[6]), .TRACE_END_I(ev[7]), .PLC_STOP_I(ev[8]),
    .MSG_EXEC_I(ev[9]), .ERR_LOG_I(ev[10]), .UNIT_RST_DONE_I(ev[26:11]),
    .RESUME_O, .COLD_START_O, .CLR_IO_MEM_O, .CLR_FORCE_O, .IOM_KEEP_O,
    .FORCE_KEEP_O, .OUTPUT_INHIBIT_INDICATOR_O, .UNIT_RST_O, .TRACE_SAMPLE_O, .UNIT_SVC_DIS_O,
    .HOST_SVC_DIS_O, .PERIPH_SVC_DIS_O, .REFRESH_DIS_O
  );

  initial begin
    forever #5 SYS_CLK_I = ~SYS_CLK_I;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // request held until waitrequest is sampled low, then released
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    AVS_ADDRESS_I <= {idx, 2'b00};
    AVS_WRITE_I <= wr;
    AVS_READ_I <= ~wr;
    AVS_WRITEDATA_I <= {16'h0000, wd};
    do begin
      @(posedge SYS_CLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
    rv = AVS_READDATA_O[15:0];
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      conclude();
    end
    @(posedge SYS_CLK_I);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] wd);
    xfer(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [15:0] exp);
    xfer(1'b0, idx, 16'h0000);
    chk(rv, exp);
  endtask

  // outputs are looked at in the one cycle a registered pulse stands
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge SYS_CLK_I);
    ev[b] <= 1'b0;
    #1;
  endtask

  task automatic mode_to(input acsa_mode_t m, input logic io, input logic fc);
    MODE_I <= m;
    @(posedge SYS_CLK_I);
    #1;
    chk({15'h0, CLR_IO_MEM_O}, {15'h0, io});
    chk({15'h0, CLR_FORCE_O}, {15'h0, fc});
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    repeat (12) @(posedge SYS_CLK_I);
    RST_B_I <= 1'b1;
    @(posedge SYS_CLK_I);
    rd(`ACSA_IX_CTL, 16'h0000);
    rd(`ACSA_IX_PTR, 16'h0000);
    rd(`ACSA_IX_ST0, 16'h4530);
    rd(`ACSA_IX_ST1, 16'h1523);
    wr(10'h002, 16'h1234);
    rd(10'h002, 16'h0000);
    tdone("reset");
    CAL_I <= 48'h9807_1610_2244;
    pulse(0);
    repeat (105) @(posedge SYS_CLK_I);
    pulse(1);
    chk({15'h0, COLD_START_O}, 16'h0001);
    chk({15'h0, RESUME_O}, 16'h0000);
    chk({15'h0, CLR_IO_MEM_O}, 16'h0001);
    chk({15'h0, CLR_FORCE_O}, 16'h0001);
    rd(`ACSA_IX_PDUR, 16'h0010);
    rd(`ACSA_IX_PT0, 16'h2244);
    rd(`ACSA_IX_PT1, 16'h1610);
    rd(`ACSA_IX_PCNT, 16'h0001);
    rd(`ACSA_IX_ST1, 16'h1610);
    wr(`ACSA_IX_CTL, 16'h1800);
    pulse(0);
    pulse(1);
    chk({15'h0, RESUME_O}, 16'h0001);
    chk({15'h0, CLR_IO_MEM_O}, 16'h0000);
    chk({15'h0, IOM_KEEP_O}, 16'h0001);
    chk({15'h0, OUTPUT_INHIBIT_INDICATOR_O}, 16'h0001);
    rd(`ACSA_IX_CTL, 16'h9800);
    rd(`ACSA_IX_PCNT, 16'h0002);
    wr(`ACSA_IX_PCNT, 16'h0005);
    rd(`ACSA_IX_PCNT, 16'h0002);
    wr(`ACSA_IX_PCNT, 16'h0000);
    rd(`ACSA_IX_PCNT, 16'h0000);
    wr(`ACSA_IX_CTL, 16'h1800);
    chk({15'h0, OUTPUT_INHIBIT_INDICATOR_O}, 16'h0000);
    tdone("power");
    mode_to(ACSA_MON, 1'b0, 1'b1);
    wr(`ACSA_IX_CTL, 16'h2000);
    chk({15'h0, FORCE_KEEP_O}, 16'h0001);
    mode_to(ACSA_DEBUG, 1'b1, 1'b0);
    mode_to(ACSA_RUN, 1'b1, 1'b1);
    tdone("mode");
    for (int i = 1; i <= 21; i++) begin
      ERR_CODE_I <= {8'hc0, 8'(i)};
      ERR_INFO_I <= {8'h5a, 8'(i)};
      pulse(10);
      if (i == 1) begin
        rd(`ACSA_IX_PTR, 16'h0001);
        rd(`ACSA_IX_LOG_LO, 16'hc001);
      end
      if (i == 20) begin
        rd(`ACSA_IX_PTR, 16'h0014);
      end
    end
    rd(`ACSA_IX_PTR, 16'h0014);
    rd(`ACSA_IX_LOG_LO, 16'hc002);
    rd(10'h0c3, 16'hc015);
    rd(10'h0c4, 16'h5a15);
    rd(10'h0c5, 16'h2244);
    rd(10'h0c6, 16'h1610);
    rd(`ACSA_IX_LOG_HI, 16'h9807);
    wr(`ACSA_IX_CTL, 16'h6000);
    rd(`ACSA_IX_CTL, 16'h2000);
    rd(`ACSA_IX_PTR, 16'h0000);
    rd(10'h0c3, 16'h0000);
    wr(`ACSA_IX_PTR, 16'h0007);
    rd(`ACSA_IX_PTR, 16'h0000);
    tdone("log");
    wr(`ACSA_IX_URST, 16'h8001);
    chk(UNIT_RST_O, 16'h8001);
    pulse(11);
    chk(UNIT_RST_O, 16'h8000);
    rd(`ACSA_IX_URST, 16'h8000);
    RM_CODE_I <= 128'h00ab << 48;
    wr(`ACSA_IX_ECHK, 16'h0008);
    repeat (3) @(posedge SYS_CLK_I);
    rd(`ACSA_IX_ECHK, 16'h0000);
    rd(10'h1d9, 16'h00ab);
    tdone("units");
    pulse(2);
    rd(`ACSA_IX_MON, 16'h0080);
    pulse(3);
    rd(`ACSA_IX_MON, 16'h0400);
    pulse(4);
    pulse(5);
    pulse(6);
    rd(`ACSA_IX_MON, 16'h7c00);
    pulse(7);
    rd(`ACSA_IX_MON, 16'h5c00);
    wr(`ACSA_IX_MON, 16'h7fff);
    rd(`ACSA_IX_MON, 16'h5c00);
    wr(`ACSA_IX_MON, 16'h8000);
    chk({15'h0, TRACE_SAMPLE_O}, 16'h0001);
    xfer(1'b0, `ACSA_IX_MON, 16'h0000);
    chk(rv & 16'ha000, 16'ha000);
    tdone("trace");
    MSG_NUM_I <= 3'h5;
    pulse(9);
    rd(`ACSA_IX_MSG, 16'h0020);
    for (int k = 0; k < 8; k++) begin
      MSG_NUM_I <= 3'(k);
      pulse(9);
    end
    rd(`ACSA_IX_MSG, 16'h00ff);
    wr(`ACSA_IX_MSG, 16'h0000);
    rd(`ACSA_IX_MSG, 16'h00ff);
    tdone("message");
    wr(`ACSA_IX_SDIS, 16'ha5a5);
    chk(UNIT_SVC_DIS_O, 16'ha5a5);
    wr(`ACSA_IX_LDIS, 16'hffff);
    rd(`ACSA_IX_LDIS, 16'h0038);
    chk({13'h0, REFRESH_DIS_O, PERIPH_SVC_DIS_O, HOST_SVC_DIS_O}, 16'h0007);
    pulse(8);
    @(posedge SYS_CLK_I);
    rd(`ACSA_IX_SDIS, 16'h0000);
    rd(`ACSA_IX_LDIS, 16'h0000);
    chk(UNIT_SVC_DIS_O, 16'h0000);
    tdone("service");
    conclude();
  end
endmodule
